/* src/fc_pkg.sv */
// Constants, register layout and carriers of the flash program/erase controller.
// Assumes a 50 MHz system clock and a synchronous-read flash array beside it.
// What this block does
// - Done flag bit 5: set at end, cleared at start
// - Fault flag bit 2: blank check fails; write 0 clears
// - Busy bit 0 set at start, cleared at end
// - Control bit 6 launches erase, auto-cleared
// - Control bit 1 selects page erase, auto-cleared
// - Control bit 0 selects programming, auto-cleared
// - Address register 0x10 gives page or word target
// - Address writes ignored while busy
// - Reserved status and control bits read zero
// - Blank check before program; skip and flag fault
// - Erase sets every page bit to one
// - Flash reads stall during operation, then complete
// - User flash is 64 pages of 512 bytes
package fc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;
   localparam logic [7:0] OFS_ADDR = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   // Status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_FAULT = 2;
   localparam int ST_DONE = 5;
   // Control field positions
   localparam int CT_PROG = 0;
   localparam int CT_PERASE = 1;
   localparam int CT_LAUNCH = 6;
   // Interrupt status and mask positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAULT = 1;
   // Reset values
   localparam logic RST_DONE = 1'b1;
   localparam logic [31:0] RST_WORD = 32'h00000000;
   localparam logic [1:0] RST_IRQ = 2'h0;
   // Array geometry: 64 pages of 512 bytes
   localparam int PAGE_BITS = 9;
   localparam int PAGE_COUNT = 64;
   localparam int ARR_AW = PAGE_BITS + $clog2(PAGE_COUNT);
   localparam logic [31:0] BLANK_WORD = 32'hffffffff;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // Register write request from the bus slave
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } fc_wreq_t;
   // Merge write data into an old value under byte strobes
   function automatic logic [31:0] fc_merge(input logic [31:0] old, input fc_wreq_t w);
      logic [31:0] m;
      m = {{8{w.strb[3]}}, {8{w.strb[2]}}, {8{w.strb[1]}}, {8{w.strb[0]}}};
      return (old & ~m) | (w.data & m);
   endfunction
endpackage

/* src/fc_axil_slave.sv */
// AXI4-Lite slave front end: takes one write and one read at a time.
// Assumes the register file answers read data and errors combinationally.
`timescale 1ns/10ps
module fc_axil_slave
   import fc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic wr_en,
   output fc_wreq_t wreq,
   input wire logic wr_err,
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_full; // Address held
   logic w_full; // Data held

   // Write path: collect both halves, pulse the write, then answer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         wr_en <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         wreq <= '0;
      end else begin
         wr_en <= 1'b0;
         // Address half taken
         if (awvalid && awready) begin
            wreq.addr <= awaddr;
            aw_full <= 1'b1;
            awready <= 1'b0;
         end
         // Data half taken
         if (wvalid && wready) begin
            wreq.data <= wdata;
            wreq.strb <= wstrb;
            w_full <= 1'b1;
            wready <= 1'b0;
         end
         // Both held: one write pulse
         if (aw_full && w_full && !wr_en && !bvalid) begin
            wr_en <= 1'b1;
         end
         // Pulse done: raise response
         if (wr_en) begin
            bvalid <= 1'b1;
            bresp <= wr_err ? RESP_DECERR : RESP_OKAY;
            aw_full <= 1'b0;
            w_full <= 1'b0;
         end
         // Response taken: reopen
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // Read path: one read pulse, data registered next cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         arready <= 1'b1;
         rd_en <= 1'b0;
         rd_addr <= 8'h00;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OKAY;
      end else begin
         rd_en <= 1'b0;
         if (arvalid && arready) begin
            rd_addr <= araddr;
            arready <= 1'b0;
            rd_en <= 1'b1;
         end
         if (rd_en) begin
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_err ? RESP_DECERR : RESP_OKAY;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule

/* src/fc_rd_port.sv */
// Flash read port for the processor side; waits while an operation runs.
// Assumes the array returns read data the cycle after it samples its read enable.
`timescale 1ns/10ps
module fc_rd_port
   import fc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic req,
   input wire logic [ARR_AW-1:0] addr,
   input wire logic stall,
   input wire logic [31:0] arr_rdata,
   output logic go,
   output logic [ARR_AW-1:0] go_addr,
   output logic valid,
   output logic [31:0] data
);
   logic pend; // Request waiting for the array
   logic [1:0] flight; // Read enable, then data cycle

   // Issue only while no operation runs
   assign go = pend && !stall;

   // Hold the request until the array is free
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pend <= 1'b0;
         go_addr <= '0;
      end else if (go) begin
         pend <= 1'b0;
      end else if (req && !pend && flight == 2'b00) begin
         pend <= 1'b1;
         go_addr <= addr;
      end
   end

   // Track the read and capture its data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flight <= 2'b00;
         valid <= 1'b0;
         data <= 32'h00000000;
      end else begin
         flight <= {flight[0], go};
         valid <= flight[1];
         if (flight[1]) begin
            data <= arr_rdata;
         end
      end
   end
endmodule

/* src/fc_flash_ctrl.sv */
// Flash program/erase controller: registers, sequencer and array drive.
// Assumes a synchronous-read array that pulses arr_done at the end of
// each program or erase, and one AXI4-Lite master.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module fc_flash_ctrl
   import fc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic [ARR_AW-1:0] arr_addr,
   output logic [31:0] arr_wdata,
   output logic arr_rd_en,
   output logic arr_prog_en,
   output logic arr_erase_en,
   input wire logic [31:0] arr_rdata,
   input wire logic arr_done,
   input wire logic cpu_rd_req,
   input wire logic [ARR_AW-1:0] cpu_rd_addr,
   output logic cpu_rd_valid,
   output logic [31:0] cpu_rd_data,
   output logic irq
);
   // Sequencer states
   typedef enum logic [2:0] {
      S_IDLE,
      S_ERASE,
      S_READ,
      S_CHECK,
      S_PROG
   } fc_state_t;

   fc_state_t state; // Sequencer state
   fc_wreq_t wreq; // Write from the bus
   logic wr_en; // Register write pulse
   logic wr_err; // Unmapped write
   logic rd_en; // Register read pulse
   logic [7:0] rd_addr; // Register read offset
   logic [31:0] rd_data; // Read mux
   logic rd_err; // Unmapped read
   logic busy; // Operation in progress
   logic done; // Last operation ended
   logic fault; // Blank check failed
   logic prog_sel; // Programming chosen
   logic perase_sel; // Page erase chosen
   logic launch; // Erase launched
   logic [31:0] prog_word; // Word to program
   logic [31:0] target; // Target address
   logic addr_loaded; // Address written since last operation
   logic [1:0] irq_stat; // Sticky event bits
   logic [1:0] irq_mask; // Event enables
   logic [31:0] next_ctrl; // Control after merge
   logic wr_ctrl; // Control write
   logic wr_data; // Data write
   logic erase_start; // Erase begins
   logic prog_start; // Program begins
   logic blank_fail; // Target not blank
   logic op_end; // Operation finished
   logic rp_go; // Read port uses the array
   logic [ARR_AW-1:0] rp_addr; // Read port address
   logic [ARR_AW-1:0] page_base; // Page aligned target

   // Bus slave
   fc_axil_slave u_bus (
      .mclk(mclk),
      .rst(rst),
      .awvalid(awvalid),
      .awready(awready),
      .awaddr(awaddr),
      .wvalid(wvalid),
      .wready(wready),
      .wdata(wdata),
      .wstrb(wstrb),
      .bvalid(bvalid),
      .bready(bready),
      .bresp(bresp),
      .arvalid(arvalid),
      .arready(arready),
      .araddr(araddr),
      .rvalid(rvalid),
      .rready(rready),
      .rdata(rdata),
      .rresp(rresp),
      .wr_en(wr_en),
      .wreq(wreq),
      .wr_err(wr_err),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // Processor read port, held off while busy
   fc_rd_port u_rd (
      .mclk(mclk),
      .rst(rst),
      .req(cpu_rd_req),
      .addr(cpu_rd_addr),
      .stall(busy || erase_start || prog_start),
      .arr_rdata(arr_rdata),
      .go(rp_go),
      .go_addr(rp_addr),
      .valid(cpu_rd_valid),
      .data(cpu_rd_data)
   );

   // Write decode and start conditions
   always_comb begin
      wr_ctrl = wr_en && wreq.addr == OFS_CTRL;
      wr_data = wr_en && wreq.addr == OFS_DATA;
      next_ctrl = fc_merge({25'h0, launch, 4'h0, perase_sel, prog_sel}, wreq);
      // Erase needs page erase select given in the same write as launch
      erase_start = wr_ctrl && !busy && next_ctrl[CT_LAUNCH]
         && next_ctrl[CT_PERASE];
      // Data write with program chosen and address loaded
      prog_start = wr_data && !busy && prog_sel && addr_loaded;
      blank_fail = state == S_CHECK && arr_rdata != BLANK_WORD;
      op_end = (state == S_ERASE || state == S_PROG) && arr_done;
      page_base = {target[ARR_AW-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
      case (wreq.addr)
         OFS_STATUS, OFS_CTRL, OFS_DATA, OFS_ADDR, OFS_IRQ_STAT, OFS_IRQ_MASK: wr_err = 1'b0;
         default: wr_err = 1'b1;
      endcase
   end

   // Register read mux; reserved bits read zero
   always_comb begin
      rd_data = 32'h00000000;
      rd_err = 1'b0;
      case (rd_addr)
         OFS_STATUS: begin
            rd_data[ST_BUSY] = busy;
            rd_data[ST_FAULT] = fault;
            rd_data[ST_DONE] = done;
         end
         OFS_CTRL: begin
            rd_data[CT_PROG] = prog_sel;
            rd_data[CT_PERASE] = perase_sel;
            rd_data[CT_LAUNCH] = launch;
         end
         OFS_DATA: rd_data = prog_word;
         OFS_ADDR: rd_data = target;
         OFS_IRQ_STAT: rd_data[1:0] = irq_stat;
         OFS_IRQ_MASK: rd_data[1:0] = irq_mask;
         default: rd_err = 1'b1;
      endcase
   end

   // Sequencer: erase waits on the array; program reads, checks, writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= S_IDLE;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (erase_start) begin
                  state <= S_ERASE;
               end else if (prog_start) begin
                  state <= S_READ;
               end
            end
            S_ERASE: if (arr_done) state <= S_IDLE;
            S_READ: state <= S_CHECK;
            // Not blank: skip the write
            S_CHECK: state <= blank_fail ? S_IDLE : S_PROG;
            S_PROG: if (arr_done) state <= S_IDLE;
         endcase
      end
   end

   // Array strobes and address, registered
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         arr_rd_en <= 1'b0;
         arr_prog_en <= 1'b0;
         arr_erase_en <= 1'b0;
         arr_addr <= '0;
         arr_wdata <= RST_WORD;
      end else begin
         arr_rd_en <= prog_start || rp_go;
         arr_erase_en <= erase_start;
         arr_prog_en <= state == S_CHECK && !blank_fail;
         if (erase_start) begin
            arr_addr <= page_base;
         end else if (prog_start) begin
            arr_addr <= {target[ARR_AW-1:2], 2'b00};
            // The starting data write lands in prog_word at this same edge
            arr_wdata <= fc_merge(prog_word, wreq);
         end else if (rp_go) begin
            arr_addr <= rp_addr;
         end
      end
   end

   // Busy and done flags
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         done <= RST_DONE;
      end else if (erase_start || prog_start) begin
         busy <= 1'b1;
         done <= 1'b0;
      end else if (op_end || blank_fail) begin
         busy <= 1'b0;
         done <= 1'b1;
      end
   end

   // Fault flag; hardware set wins over a clearing write
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fault <= 1'b0;
      end else if (blank_fail) begin
         fault <= 1'b1;
      end else if (wr_en && wreq.addr == OFS_STATUS && wreq.strb[0]
         && !wreq.data[ST_FAULT]) begin
         fault <= 1'b0;
      end
   end

   // Control bits: set by software while idle, cleared as busy falls
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prog_sel <= 1'b0;
         perase_sel <= 1'b0;
         launch <= 1'b0;
      end else if (op_end || blank_fail) begin
         prog_sel <= 1'b0;
         perase_sel <= 1'b0;
         launch <= 1'b0;
      end else if (wr_ctrl && !busy) begin
         prog_sel <= next_ctrl[CT_PROG];
         perase_sel <= next_ctrl[CT_PERASE];
         launch <= next_ctrl[CT_LAUNCH] && next_ctrl[CT_PERASE];
      end
   end

   // Program word and target address
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prog_word <= RST_WORD;
         target <= RST_WORD;
         addr_loaded <= 1'b0;
      end else begin
         if (wr_data && !busy) begin
            prog_word <= fc_merge(prog_word, wreq);
         end
         // Frozen while busy
         if (wr_en && wreq.addr == OFS_ADDR && !busy) begin
            target <= fc_merge(target, wreq);
            addr_loaded <= 1'b1;
         end else if (op_end || blank_fail) begin
            addr_loaded <= 1'b0;
         end
      end
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_stat <= RST_IRQ;
         irq_mask <= RST_IRQ;
         irq <= 1'b0;
      end else begin
         if (wr_en && wreq.addr == OFS_IRQ_STAT && wreq.strb[0]) begin
            irq_stat <= (irq_stat & ~wreq.data[1:0])
               | {blank_fail, op_end || blank_fail};
         end else begin
            irq_stat <= irq_stat | {blank_fail, op_end || blank_fail};
         end
         if (wr_en && wreq.addr == OFS_IRQ_MASK && wreq.strb[0]) begin
            irq_mask <= wreq.data[1:0];
         end
         irq <= |(irq_stat & irq_mask);
      end
   end
endmodule

/* test/fc_flash_ctrl_props.sv */
// Concurrent checks on the flash controller's top-level ports.
// Bound onto fc_flash_ctrl from the bench; one clock, reset active high.
`timescale 1ns/10ps
module fc_flash_ctrl_props
   import fc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [ARR_AW-1:0] arr_addr,
   input wire logic arr_rd_en,
   input wire logic arr_prog_en,
   input wire logic arr_erase_en,
   input wire logic [31:0] arr_rdata,
   input wire logic arr_done,
   input wire logic cpu_rd_valid
);
   logic in_op; // Array busy with program or erase
   // Window from array start pulse to its done pulse
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         in_op <= 1'b0;
      end else if (arr_prog_en || arr_erase_en) begin
         in_op <= 1'b1;
      end else if (arr_done) begin
         in_op <= 1'b0;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_erase_page_align: assert property (arr_erase_en |-> arr_addr[8:0] == 9'h0)
      else $error("erase address not on a page boundary");
   a_one_strobe: assert property ($onehot0({arr_rd_en, arr_prog_en, arr_erase_en}))
      else $error("more than one array strobe");
   a_no_dirty_prog: assert property (arr_rd_en ##1 (arr_rdata != BLANK_WORD)
      |=> !arr_prog_en [*4])
      else $error("program issued over a dirty word");
   a_op_addr_hold: assert property (in_op |-> $stable(arr_addr))
      else $error("array address moved during operation");
   a_read_stall: assert property (cpu_rd_valid |-> !in_op)
      else $error("flash read answered during operation");
   a_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##[2:4] bvalid)
      else $error("write response late");
   a_r_answer: assert property (arvalid && arready |-> ##[1:3] rvalid)
      else $error("read response late");
   a_b_hold: assert property ($fell(bvalid) |-> $past(bready))
      else $error("write response dropped");
   a_r_hold: assert property ($fell(rvalid) |-> $past(rready))
      else $error("read data dropped");
endmodule

/* test/fc_flash_model.sv */
// Behavioural flash array: 64 pages of 512 bytes, synchronous read.
// Program and erase end with a done pulse after lat+1 cycles.
`timescale 1ns/10ps
module fc_flash_model
   import fc_pkg::*;
(
   input wire logic mclk,
   input wire logic [ARR_AW-1:0] arr_addr,
   input wire logic [31:0] arr_wdata,
   input wire logic arr_rd_en,
   input wire logic arr_prog_en,
   input wire logic arr_erase_en,
   input wire logic [3:0] lat,
   output logic [31:0] arr_rdata,
   output logic arr_done
);
   logic [31:0] mem [0:PAGE_COUNT*128-1]; // Word store
   int cnt = 0; // Cycles left in operation
   initial begin
      arr_rdata = 32'h0;
      arr_done = 1'b0;
      for (int i = 0; i < PAGE_COUNT*128; i++) mem[i] = BLANK_WORD;
   end
   // Read, program, erase and completion timing
   always @(posedge mclk) begin
      arr_done <= 1'b0;
      arr_rdata <= ~arr_rdata; // Released data keeps changing
      if (arr_rd_en) begin
         arr_rdata <= mem[arr_addr[ARR_AW-1:2]];
      end
      if (arr_prog_en) begin
         mem[arr_addr[ARR_AW-1:2]] <= mem[arr_addr[ARR_AW-1:2]] & arr_wdata;
         cnt <= lat + 1;
      end
      if (arr_erase_en) begin
         // Whole page to ones
         for (int j = 0; j < 128; j++) mem[{arr_addr[ARR_AW-1:9], j[6:0]}] <= BLANK_WORD;
         cnt <= lat + 1;
      end
      if (cnt == 1) arr_done <= 1'b1;
      if (cnt != 0 && !arr_prog_en && !arr_erase_en) cnt <= cnt - 1;
   end
endmodule

/* test/fc_flash_ctrl_tb.sv */
// Self-checking bench for the flash controller with an array model.
// Register traffic over AXI4-Lite; expected results queued for a monitor.
`timescale 1ns/10ps
module fc_flash_ctrl_tb;
   import fc_pkg::*;
   logic mclk = 0, rst = 1;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, arr_wdata, arr_rdata, cpu_rd_data;
   logic [3:0] wstrb = 0, lat = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, irq, cpu_rd_req = 0, cpu_rd_valid;
   logic [1:0] bresp, rresp;
   logic [ARR_AW-1:0] arr_addr, cpu_rd_addr = 0;
   logic arr_rd_en, arr_prog_en, arr_erase_en, arr_done;
   logic [33:0] exp_q [$]; // Expected {resp, data}
   logic [31:0] tgt, dat;
   int err_count = 0, check_count = 0;
   logic [7:0] offs [5] = '{OFS_CTRL, OFS_DATA, OFS_ADDR, OFS_IRQ_STAT, OFS_IRQ_MASK};
   fc_flash_ctrl fc_flash_ctrl_inst (.mclk(mclk), .rst(rst), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rd_en(arr_rd_en),
      .arr_prog_en(arr_prog_en), .arr_erase_en(arr_erase_en), .arr_rdata(arr_rdata),
      .arr_done(arr_done), .cpu_rd_req(cpu_rd_req), .cpu_rd_addr(cpu_rd_addr),
      .cpu_rd_valid(cpu_rd_valid), .cpu_rd_data(cpu_rd_data), .irq(irq));
   fc_flash_model fc_flash_model_inst (.mclk(mclk), .arr_addr(arr_addr),
      .arr_wdata(arr_wdata), .arr_rd_en(arr_rd_en), .arr_prog_en(arr_prog_en),
      .arr_erase_en(arr_erase_en), .lat(lat), .arr_rdata(arr_rdata), .arr_done(arr_done));
   // 50 MHz clock
   initial begin
      forever #10 mclk = ~mclk;
   end
   // Compare seen against expected
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Register write; response code queued
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      exp_q.push_back({r, 32'h0});
      @(posedge mclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      bready <= 1'b1; // Ready offered with the request
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
   endtask
   // Register read; data and response queued
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
      exp_q.push_back({r, e});
      @(posedge mclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1; // Ready offered with the request
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
   endtask
   // Flash read on the processor port, waits for its answer
   task automatic cpu_rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back({2'b0, e});
      @(posedge mclk);
      cpu_rd_req <= 1'b1;
      cpu_rd_addr <= a[ARR_AW-1:0];
      @(posedge mclk);
      cpu_rd_req <= 1'b0;
      for (int i = 0; i < 300 && cpu_rd_valid !== 1'b1; i++) @(posedge mclk);
      // No answer in time counts as a mismatch
      if (cpu_rd_valid !== 1'b1) err_count++;
   endtask
   // Wait for the end-of-operation interrupt
   task automatic wait_irq;
      for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge mclk);
      chk({33'h0, irq}, 34'h1);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Monitor: each result against the oldest note
   always @(posedge mclk) begin
      if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
      if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
      if (cpu_rd_valid) chk({2'b0, cpu_rd_data}, exp_q.pop_front());
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      give_verdict();
   end
   initial begin
      void'($urandom(32059));
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rd(OFS_STATUS, 32'h20);
      foreach (offs[i]) rd(offs[i], 32'h0);
      wr(8'h1c, 32'h1, RESP_DECERR);
      rd(8'h1c, 32'h0, RESP_DECERR);
      wr(OFS_CTRL, 32'hffffffbc);
      rd(OFS_CTRL, 32'h0);
      $display("test reset done");
      tgt = $urandom & 32'h7ffc;
      dat = $urandom >> 1;
      wr(OFS_IRQ_MASK, 32'h3);
      wr(OFS_CTRL, 32'h1);
      rd(OFS_CTRL, 32'h1);
      wr(OFS_ADDR, tgt);
      wr(OFS_DATA, dat);
      rd(OFS_STATUS, 32'h1);
      wr(OFS_ADDR, ~tgt);
      cpu_rd(tgt, dat);
      wait_irq();
      rd(OFS_ADDR, tgt);
      rd(OFS_STATUS, 32'h20);
      rd(OFS_CTRL, 32'h0);
      chk({2'b0, fc_flash_model_inst.mem[tgt[ARR_AW-1:2]]}, {2'b0, dat});
      $display("test program done");
      wr(OFS_IRQ_STAT, 32'h3);
      wr(OFS_CTRL, 32'h1);
      wr(OFS_ADDR, tgt);
      wr(OFS_DATA, ~dat);
      wait_irq();
      rd(OFS_STATUS, 32'h24);
      rd(OFS_IRQ_STAT, 32'h3);
      chk({2'b0, fc_flash_model_inst.mem[tgt[ARR_AW-1:2]]}, {2'b0, dat});
      wr(OFS_IRQ_MASK, 32'h0);
      repeat (2) @(posedge mclk);
      chk({33'h0, irq}, 34'h0);
      wr(OFS_IRQ_MASK, 32'h3);
      wr(OFS_STATUS, 32'h0);
      rd(OFS_STATUS, 32'h20);
      wr(OFS_IRQ_STAT, 32'h3);
      repeat (2) @(posedge mclk);
      chk({33'h0, irq}, 34'h0);
      $display("test fault done");
      lat <= $urandom_range(0, 15);
      wr(OFS_CTRL, 32'h40);
      rd(OFS_CTRL, 32'h0);
      wr(OFS_CTRL, 32'h2);
      rd(OFS_CTRL, 32'h2);
      wr(OFS_ADDR, tgt ^ ($urandom & 32'h1fc));
      wr(OFS_CTRL, 32'h42);
      wait_irq();
      rd(OFS_CTRL, 32'h0);
      rd(OFS_IRQ_STAT, 32'h1);
      chk({2'b0, fc_flash_model_inst.mem[tgt[ARR_AW-1:2]]}, {2'b0, BLANK_WORD});
      cpu_rd(tgt & 32'h7e00, BLANK_WORD);
      cpu_rd(tgt | 32'h1fc, BLANK_WORD);
      $display("test erase done");
      give_verdict();
   end
endmodule
bind fc_flash_ctrl fc_flash_ctrl_props props_inst (.mclk(mclk), .rst(rst),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
   .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .arr_addr(arr_addr), .arr_rd_en(arr_rd_en),
   .arr_prog_en(arr_prog_en), .arr_erase_en(arr_erase_en), .arr_rdata(arr_rdata),
   .arr_done(arr_done), .cpu_rd_valid(cpu_rd_valid));
